// ===== adc_pointer_register_access_test.sv
// Self-checking bench for the two-wire register access block.
`timescale 1ns/1ps
module adc_pointer_register_access_test;
    import apr_pkg::*;
    // ------------------------------------------------------------
    // Signals, clock and instances
    // ------------------------------------------------------------
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic sclLine, sdaLine, sdaOut, sdaOe, convDone, convBusy, convStart, gcallReset, ok;
    logic singleShotMode, cmpType, cmpPolarity, cmpLatching;
    logic [1:0] strapSel, cmpQueue;
    logic [2:0] inputSelect, gainRange, sampleRateSel;
    logic signed [15:0] rawSample;
    logic [15:0] lowLimitReg, highLimitReg, cfgSeen, rd, expCfg, expRes;
    logic [15:0] corner [8] = '{16'h0001, 16'hffff, 16'h7fff, 16'h8000, 16'h07ff, 16'hf800,
        16'h0800, 16'hf7ff};
    logic [31:0] seed = 32'h984c067e;
    int nMismatch = 0, testsRun = 0, cycles = 0, nGcall = 0, nStart = 0;
    always #2 mclk = ~mclk;
    assign cfgSeen = {1'b0, inputSelect, gainRange, singleShotMode, sampleRateSel, cmpType,
        cmpPolarity, cmpLatching, cmpQueue};
    apr_register_access #(.RAW_W(16), .HAS_CMP(1'b1)) u_apr_register_access (
        .mclk(mclk), .rst_n(rst_n), .sclIn(sclLine), .sdaIn(sdaLine), .sdaOut(sdaOut),
        .sdaOe(sdaOe), .strapSel(strapSel), .convDone(convDone), .rawSample(rawSample),
        .convBusy(convBusy), .convStart(convStart), .gcallReset(gcallReset),
        .inputSelect(inputSelect), .gainRange(gainRange), .singleShotMode(singleShotMode),
        .sampleRateSel(sampleRateSel), .cmpType(cmpType), .cmpPolarity(cmpPolarity),
        .cmpLatching(cmpLatching), .cmpQueue(cmpQueue), .lowLimitReg(lowLimitReg),
        .highLimitReg(highLimitReg));
    apr_bus_ctrl u_apr_bus_ctrl (.mclk(mclk), .sdaOe(sdaOe), .sclLine(sclLine),
        .sdaLine(sdaLine));
    // Counts one-cycle pulses and cuts a hang short.
    always @(posedge mclk)
    begin
        nGcall += int'(gcallReset === 1'b1);
        nStart += int'(convStart === 1'b1);
        cycles++;
        if (cycles == 60000)
        begin
            nMismatch++;
            endOfTest();
        end
    end
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xorshift
    // Clamped, left-justified result word for a raw sample.
    function automatic logic [15:0] expResult(input logic signed [15:0] raw);
        if (raw > 16'sd2047) return 16'h7ff0;
        if (raw < -16'sd2048) return 16'h8000;
        return {raw[11:0], 4'h0};
    endfunction : expResult
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        testsRun++;
        if (got !== exp)
        begin
            nMismatch++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic regWrite(input logic [1:0] sel, input logic full, input logic [15:0] data,
        input logic hold);
        logic ack;
        u_apr_bus_ctrl.writeReg({5'b10010, strapSel}, {6'h00, sel}, full, data, hold, ack);
        chk("write ack", 16'h0001, {15'h0, ack});
    endtask : regWrite
    task automatic rdWord(input logic two, output logic [15:0] data);
        logic ack;
        u_apr_bus_ctrl.readReg({5'b10010, strapSel}, two, data, ack);
        chk("read ack", 16'h0001, {15'h0, ack});
    endtask : rdWord
    task automatic endOfTest();
        if (nMismatch == 0 && testsRun > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : endOfTest
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        strapSel = 2'h0;
        convDone = 1'b0;
        convBusy = 1'b0;
        rawSample = 16'sh0000;
        repeat (6) @(posedge mclk);
        #1 rst_n = 1'b1;
        repeat (4) @(posedge mclk);
        #1;
        chk("config fields", 16'h0583, cfgSeen);
        chk("data drive level", 16'h0000, {15'h0, sdaOut});
        chk("low limit", LOWLIM_RESET, lowLimitReg);
        chk("high limit", HIGHLIM_RESET, highLimitReg);
        rdWord(1'b1, rd);
        chk("result after reset", 16'h0000, rd);
        // Every strap setting, a foreign address, select-only writes and the status bit.
        for (int s = 0; s < 4; s++)
        begin
            strapSel = 2'(s);
            convBusy = s[0];
            u_apr_bus_ctrl.writeReg({5'b10010, 2'(s + 1)}, 8'h01, 1'b0, 16'h0, 1'b0, ok);
            chk("foreign address ack", 16'h0000, {15'h0, ok});
            regWrite(SEL_CONFIG, 1'b0, 16'h0, 1'b0);
            rdWord(1'b1, rd);
            chk("config read", {~s[0], 15'h0583}, rd);
        end
        convBusy = 1'b0;
        // Random configuration words, read twice; odd passes read after a repeated start.
        for (int i = 0; i < 4; i++)
        begin
            seed = xorshift(seed);
            expCfg = {1'b0, seed[14:0]};
            regWrite(SEL_CONFIG, 1'b1, expCfg, i[0]);
            chk("config fields", expCfg, cfgSeen);
            rdWord(1'b1, rd);
            chk("config read", expCfg | 16'h8000, rd);
            rdWord(1'b1, rd);
            chk("config reread", expCfg | 16'h8000, rd);
        end
        // Conversions: corner codes first, then random ones.
        for (int i = 0; i < 10; i++)
        begin
            seed = xorshift(seed);
            rawSample = (i < 8) ? corner[i] : {{3{seed[12]}}, seed[12:0]};
            convDone = 1'b1;
            @(posedge mclk);
            #1;
            convDone = 1'b0;
            expRes = expResult(rawSample);
            if (i == 0) regWrite(SEL_RESULT, 1'b0, 16'h0, 1'b0);
            rdWord(1'b1, rd);
            chk("result", expRes, rd);
        end
        rdWord(1'b0, rd);
        chk("result high byte", {expRes[15:8], 8'h00}, rd);
        regWrite(SEL_RESULT, 1'b1, 16'h1230, 1'b0);
        rdWord(1'b1, rd);
        chk("result after write", expRes, rd);
        // Both limit registers through the bus and at the ports.
        for (int i = 2; i < 4; i++)
        begin
            seed = xorshift(seed);
            regWrite(2'(i), 1'b1, seed[15:0], 1'b0);
            rdWord(1'b1, rd);
            chk("limit read", seed[15:0], rd);
            chk("limit port", seed[15:0], (i == 2) ? lowLimitReg : highLimitReg);
        end
        // General call reset, then a single-shot start request.
        u_apr_bus_ctrl.writeReg(7'h00, 8'h06, 1'b0, 16'h0, 1'b0, ok);
        chk("general call ack", 16'h0001, {15'h0, ok});
        chk("reset pulses", 16'h0001, 16'(nGcall));
        chk("config fields", 16'h0583, cfgSeen);
        rdWord(1'b1, rd);
        chk("result after general reset", 16'h0000, rd);
        // A start request while a conversion runs must not pulse the start output.
        convBusy = 1'b1;
        regWrite(SEL_CONFIG, 1'b1, 16'h8583, 1'b0);
        chk("start while busy", 16'h0000, 16'(nStart));
        convBusy = 1'b0;
        regWrite(SEL_CONFIG, 1'b1, 16'h8583, 1'b0);
        chk("start pulses", 16'h0001, 16'(nStart));
        endOfTest();
    end
endmodule : adc_pointer_register_access_test

// ===== apr_bus_ctrl.sv
// Two-wire bus controller model that issues register reads and writes.
`timescale 1ns/1ps
module apr_bus_ctrl (
    input wire logic mclk,
    input wire logic sdaOe,
    output logic sclLine,
    output logic sdaLine
);
    // ------------------------------------------------------------
    // Open-drain line and bit timing
    // ------------------------------------------------------------
    // A quarter bit in mclk cycles; the clock stays low for ten cycles.
    localparam int Q = 5;
    logic pullLow;
    // The pull-up wins unless a party pulls the data line low.
    assign sdaLine = ~(pullLow | sdaOe);
    initial
    begin
        sclLine = 1'b1;
        pullLow = 1'b0;
    end
    // Waits whole cycles and steps just past the edge.
    task automatic waitq(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : waitq
    // Start, or repeated start when the clock is low; leaves the clock low.
    task automatic start();
        if (!sclLine)
        begin
            pullLow = 1'b0;
            waitq(Q);
            sclLine = 1'b1;
            waitq(Q);
        end
        pullLow = 1'b1;
        waitq(Q);
        sclLine = 1'b0;
        waitq(Q);
    endtask : start
    // Stop ends the transfer and leaves the bus idle.
    task automatic stop();
        pullLow = 1'b1;
        waitq(Q);
        sclLine = 1'b1;
        waitq(Q);
        pullLow = 1'b0;
        waitq(2 * Q);
    endtask : stop
    // One bit: a one releases the line, the level is sampled while the clock is high.
    task automatic xferBit(input logic b, output logic r);
        pullLow = ~b;
        waitq(Q);
        sclLine = 1'b1;
        waitq(Q);
        r = sdaLine;
        waitq(Q);
        sclLine = 1'b0;
        waitq(Q);
    endtask : xferBit
    // Eight bits most significant first, then the acknowledge slot.
    task automatic xferByte(input logic [7:0] tx, input logic ackBit, output logic [7:0] rx,
        output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) xferBit(tx[i], rx[i]);
        xferBit(ackBit, r);
        ack = ~r;
    endtask : xferByte
    // Write: address with write bit, select byte first, then an optional word.
    task automatic writeReg(input logic [6:0] addr, input logic [7:0] sel, input logic full,
        input logic [15:0] data, input logic hold, output logic ok);
        logic [7:0] rx;
        logic a0, a1, a2, a3;
        a2 = 1'b1;
        a3 = 1'b1;
        start();
        xferByte({addr, 1'b0}, 1'b1, rx, a0);
        xferByte(sel, 1'b1, rx, a1);
        if (full) xferByte(data[15:8], 1'b1, rx, a2);
        if (full) xferByte(data[7:0], 1'b1, rx, a3);
        if (!hold) stop();
        ok = a0 & a1 & a2 & a3;
    endtask : writeReg
    // Read one or two bytes; the last byte is refused with a high acknowledge slot.
    task automatic readReg(input logic [6:0] addr, input logic two, output logic [15:0] data,
        output logic ok);
        logic ax;
        data = 16'h0000;
        start();
        xferByte({addr, 1'b1}, 1'b1, data[15:8], ok);
        xferByte(8'hff, ~two, data[15:8], ax);
        if (two) xferByte(8'hff, 1'b1, data[7:0], ax);
        stop();
    endtask : readReg
endmodule : apr_bus_ctrl

// ===== apr_pkg.sv
// Shared constants and types for the two-wire register access block.
package apr_pkg;

    // ----------------------------------------------------------------
    // Register selector codes and register layout
    // ----------------------------------------------------------------
    localparam logic [1:0] SEL_RESULT = 2'h0;
    localparam logic [1:0] SEL_CONFIG = 2'h1;
    localparam logic [1:0] SEL_LOWLIM = 2'h2;
    localparam logic [1:0] SEL_HIGHLIM = 2'h3;
    localparam logic [1:0] SEL_RESET = 2'h0;
    localparam logic [15:0] CONFIG_RESET = 16'h8583;
    localparam logic [15:0] RESULT_RESET = 16'h0000;
    localparam logic [15:0] LOWLIM_RESET = 16'h8000;
    localparam logic [15:0] HIGHLIM_RESET = 16'h7ff0;
    localparam logic [15:0] ABSENT_READ = 16'h0000;
    localparam logic [3:0] RESULT_PAD = 4'h0;
    localparam int CFG_START_BIT = 15;
    localparam int CFG_MODE_BIT = 8;

    // ----------------------------------------------------------------
    // Conversion code limits (12-bit two's complement)
    // ----------------------------------------------------------------
    localparam int CODE_W = 12;
    localparam int CODE_MAX = 2047;
    localparam int CODE_MIN = -2048;
    localparam logic [11:0] CODE_POS_FS = 12'h7ff;
    localparam logic [11:0] CODE_NEG_FS = 12'h800;

    // ----------------------------------------------------------------
    // Bus framing constants
    // ----------------------------------------------------------------
    localparam logic [4:0] TARGET_BASE = 5'h12;
    localparam logic [7:0] GCALL_ADDR = 8'h00;
    localparam logic [7:0] GCALL_RESET = 8'h06;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] LAST_TX_BIT = 4'h7;
    localparam logic [1:0] IDX_SELECT = 2'h0;
    localparam logic [1:0] IDX_MSB = 2'h1;
    localparam logic [1:0] IDX_LSB = 2'h2;

    // Protocol engine states.
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ACK,
        ST_RX,
        ST_TX,
        ST_TXACK
    } apr_state_e;

endpackage : apr_pkg

// ===== apr_register_access.sv
// Two-wire bus target with register selector, result and configuration registers.
//
// Overview of operation
// - Device acknowledges the select byte; controller then stops or restarts.
// - Every read returns the register picked by the latest written selector, or the result register after a general call reset.
// - Selector persists across transfers until another write changes it.
// - Address plus select byte then stop only updates the selector.
// - Two low target address bits follow the address strap.
// - Results are 12-bit two's complement, left justified in 16 bits.
// - Results saturate at 7FF0h and 8000h beyond full scale.
// - Select byte resets to zero; low two bits choose among four registers.
// - Result register holds latest conversion and reads zero after power-up.
// - Result is read-only; bits 3 down to 0 always read zero.
// - Limit registers read zero without comparator; configuration steers and reports.
// - Configuration resets to 8583h with the listed field layout.
// - Sixteen-bit registers travel most significant byte first.
// - Target address is 1001000 to 1001011 by strap setting.
// - General call with 06h resets registers and enters power-down.
`timescale 1ns/1ps
module apr_register_access
    import apr_pkg::*;
#(
    parameter int RAW_W = 16,
    parameter bit HAS_CMP = 1'b1
)(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    input wire logic [1:0] strapSel,
    input wire logic convDone,
    input wire logic signed [RAW_W-1:0] rawSample,
    input wire logic convBusy,
    output logic convStart,
    output logic gcallReset,
    output logic [2:0] inputSelect,
    output logic [2:0] gainRange,
    output logic singleShotMode,
    output logic [2:0] sampleRateSel,
    output logic cmpType,
    output logic cmpPolarity,
    output logic cmpLatching,
    output logic [1:0] cmpQueue,
    output logic [15:0] lowLimitReg,
    output logic [15:0] highLimitReg
);

    // ----------------------------------------------------------------
    // State record
    // ----------------------------------------------------------------
    typedef struct packed {
        logic sclS1;
        logic sclS2;
        logic sclPrev;
        logic sdaS1;
        logic sdaS2;
        logic sdaPrev;
        logic [1:0] strapS1;
        logic [1:0] strapS2;
        apr_state_e state;
        logic [3:0] bitCnt;
        logic [7:0] shift;
        logic [1:0] byteIdx;
        logic isRead;
        logic isGcall;
        logic sdaDrive;
        logic ackd;
        logic [1:0] selector;
        logic [15:0] txWord;
        logic [7:0] msbHold;
        logic [15:0] result;
        logic [14:0] cfg;
        logic [15:0] lowLim;
        logic [15:0] highLim;
        logic convStart;
        logic gcallReset;
    } apr_state_s;

    localparam apr_state_s STATE_RESET = '{
        sclS1: 1'b1, sclS2: 1'b1, sclPrev: 1'b1,
        sdaS1: 1'b1, sdaS2: 1'b1, sdaPrev: 1'b1,
        strapS1: 2'h0, strapS2: 2'h0, state: ST_IDLE,
        bitCnt: 4'h0, shift: 8'h00, byteIdx: IDX_SELECT,
        isRead: 1'b0, isGcall: 1'b0, sdaDrive: 1'b0, ackd: 1'b0,
        selector: SEL_RESET, txWord: 16'h0000, msbHold: 8'h00,
        result: RESULT_RESET, cfg: CONFIG_RESET[14:0],
        lowLim: LOWLIM_RESET, highLim: HIGHLIM_RESET,
        convStart: 1'b0, gcallReset: 1'b0
    };

    apr_state_s q;
    apr_state_s d;

    // Clamps a raw sample into the 12-bit code range and left-justifies it.
    function automatic logic [15:0] satCode(input logic signed [RAW_W-1:0] raw);
        logic [11:0] code;
        code = raw[CODE_W-1:0];
        if (raw > CODE_MAX) code = CODE_POS_FS;
        if (raw < CODE_MIN) code = CODE_NEG_FS;
        return {code, RESULT_PAD};
    endfunction : satCode

    // Read multiplexer; limit registers read zero when the comparator is absent.
    function automatic logic [15:0] regRead(input apr_state_s s, input logic busy);
        logic [15:0] v;
        case (s.selector)
            SEL_RESULT: v = s.result;
            SEL_CONFIG: v = {~busy, s.cfg};
            SEL_LOWLIM: v = HAS_CMP ? s.lowLim : ABSENT_READ;
            default: v = HAS_CMP ? s.highLim : ABSENT_READ;
        endcase
        return v;
    endfunction : regRead

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    logic sclRise;
    logic sclFall;
    logic startCond;
    logic stopCond;
    logic byteDone;
    logic [6:0] myAddr;

    // Bus condition decode on the synchronised lines.
    always_comb
    begin
        sclRise = q.sclS2 & ~q.sclPrev;
        sclFall = ~q.sclS2 & q.sclPrev;
        startCond = q.sclS2 & q.sclPrev & q.sdaPrev & ~q.sdaS2;
        stopCond = q.sclS2 & q.sclPrev & ~q.sdaPrev & q.sdaS2;
        byteDone = sclFall & (q.bitCnt == BITS_PER_BYTE);
        myAddr = {TARGET_BASE, q.strapS2};
    end

    // Protocol engine and register updates.
    always_comb
    begin
        d = q;
        d.sclS1 = sclIn;
        d.sclS2 = q.sclS1;
        d.sclPrev = q.sclS2;
        d.sdaS1 = sdaIn;
        d.sdaS2 = q.sdaS1;
        d.sdaPrev = q.sdaS2;
        d.strapS1 = strapSel;
        d.strapS2 = q.strapS1;
        d.convStart = 1'b0;
        d.gcallReset = 1'b0;
        if (startCond)
        begin
            d.state = ST_ADDR;
            d.bitCnt = 4'h0;
            d.byteIdx = IDX_SELECT;
            d.sdaDrive = 1'b0;
        end
        else if (stopCond)
        begin
            d.state = ST_IDLE;
            d.sdaDrive = 1'b0;
        end
        else
        begin
            case (q.state)
                ST_ADDR, ST_RX:
                begin
                    if (sclRise)
                    begin
                        d.shift = {q.shift[6:0], q.sdaS2};
                        d.bitCnt = q.bitCnt + 4'h1;
                    end
                    if (byteDone)
                    begin
                        d.bitCnt = 4'h0;
                        d.state = ST_ACK;
                        d.sdaDrive = 1'b1;
                        if (q.state == ST_ADDR)
                        begin
                            d.isGcall = 1'b0;
                            d.isRead = q.shift[0];
                            if (q.shift[7:1] == myAddr)
                            begin
                                d.txWord = regRead(q, convBusy);
                            end
                            else if (q.shift == GCALL_ADDR)
                            begin
                                d.isGcall = 1'b1;
                            end
                            else
                            begin
                                d.state = ST_IDLE;
                                d.sdaDrive = 1'b0;
                            end
                        end
                        else if (q.isGcall)
                        begin
                            if (q.shift == GCALL_RESET)
                            begin
                                d.selector = SEL_RESET;
                                d.result = RESULT_RESET;
                                d.cfg = CONFIG_RESET[14:0];
                                d.lowLim = LOWLIM_RESET;
                                d.highLim = HIGHLIM_RESET;
                                d.gcallReset = 1'b1;
                            end
                        end
                        else
                        begin
                            d.byteIdx = (q.byteIdx == IDX_LSB) ? IDX_MSB : q.byteIdx + 2'h1;
                            case (q.byteIdx)
                                IDX_SELECT: d.selector = q.shift[1:0];
                                IDX_MSB: d.msbHold = q.shift;
                                default:
                                begin
                                    case (q.selector)
                                        SEL_CONFIG:
                                        begin
                                            d.cfg = {q.msbHold[6:0], q.shift};
                                            d.convStart = q.msbHold[7] & q.cfg[CFG_MODE_BIT]
                                                & ~convBusy;
                                        end
                                        SEL_LOWLIM: d.lowLim = {q.msbHold, q.shift};
                                        SEL_HIGHLIM: d.highLim = {q.msbHold, q.shift};
                                        default: d.result = q.result;
                                    endcase
                                end
                            endcase
                        end
                    end
                end
                ST_ACK:
                begin
                    if (sclFall)
                    begin
                        d.state = q.isRead ? ST_TX : ST_RX;
                        d.sdaDrive = q.isRead & ~q.txWord[15];
                    end
                end
                ST_TX:
                begin
                    if (sclFall)
                    begin
                        d.txWord = {q.txWord[14:0], q.txWord[15]};
                        d.bitCnt = q.bitCnt + 4'h1;
                        d.sdaDrive = ~q.txWord[14];
                        if (q.bitCnt == LAST_TX_BIT)
                        begin
                            d.state = ST_TXACK;
                            d.sdaDrive = 1'b0;
                            d.bitCnt = 4'h0;
                        end
                    end
                end
                ST_TXACK:
                begin
                    if (sclRise) d.ackd = ~q.sdaS2;
                    if (sclFall)
                    begin
                        d.state = q.ackd ? ST_TX : ST_IDLE;
                        d.sdaDrive = q.ackd & ~q.txWord[15];
                    end
                end
                default: d.sdaDrive = 1'b0;
            endcase
        end
        // A finished conversion always lands, even beside a general call reset.
        if (convDone) d.result = satCode(rawSample);
    end

    // State register.
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n) q <= STATE_RESET;
        else q <= d;
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    // Open-drain data line: only ever pulled low.
    assign sdaOut = 1'b0;
    assign sdaOe = q.sdaDrive;
    assign convStart = q.convStart;
    assign gcallReset = q.gcallReset;
    // Configuration fields steer the converter.
    assign inputSelect = q.cfg[14:12];
    assign gainRange = q.cfg[11:9];
    assign singleShotMode = q.cfg[CFG_MODE_BIT];
    assign sampleRateSel = q.cfg[7:5];
    assign cmpType = q.cfg[4];
    assign cmpPolarity = q.cfg[3];
    assign cmpLatching = q.cfg[2];
    assign cmpQueue = q.cfg[1:0];
    assign lowLimitReg = q.lowLim;
    assign highLimitReg = q.highLim;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    logic ptrByte;
    logic gcReset;
    assign ptrByte = byteDone & (q.state == ST_RX) & ~q.isGcall & (q.byteIdx == IDX_SELECT)
        & ~startCond & ~stopCond;
    assign gcReset = byteDone & (q.state == ST_RX) & q.isGcall & (q.shift == GCALL_RESET)
        & ~startCond & ~stopCond & ~convDone;

    a_result_pad_zero: assert property (q.result[3:0] == RESULT_PAD)
        else $error("result low nibble not zero");
    a_sat_positive: assert property (convDone && rawSample > CODE_MAX |=> q.result == 16'h7ff0)
        else $error("positive saturation wrong");
    a_sat_negative: assert property (convDone && rawSample < CODE_MIN |=> q.result == 16'h8000)
        else $error("negative saturation wrong");
    a_one_lsb: assert property (convDone && rawSample == -1 |=> q.result == 16'hfff0)
        else $error("negative one code wrong");
    a_select_hold: assert property ($changed(q.selector) |-> $past(q.state) == ST_RX)
        else $error("selector changed outside a write");
    a_addr_ack: assert property (byteDone && q.state == ST_ADDR && !startCond && !stopCond
        && q.shift[7:1] == myAddr |=> q.sdaDrive && q.state == ST_ACK)
        else $error("own address not acknowledged");
    a_select_ack: assert property (ptrByte |=> q.sdaDrive && q.selector == $past(q.shift[1:0])
        ##1 (q.state == ST_ACK)[*1])
        else $error("select byte not stored or acknowledged");
    a_gcall_reset: assert property (gcReset |=> q.cfg == CONFIG_RESET[14:0]
        && q.selector == SEL_RESET && gcallReset)
        else $error("general call reset incomplete");
    a_tx_msb_first: assert property (q.state == ST_ACK && q.isRead && sclFall && !startCond
        && !stopCond |=> sdaOe == ~$past(q.txWord[15]))
        else $error("read does not start with msb");

    c_read_xfer: cover property (q.state == ST_TXACK ##1 q.state == ST_TX);
    c_select_only: cover property (ptrByte ##[1:200] stopCond);
    c_gcall: cover property (gcReset);
    c_saturate: cover property (convDone && rawSample > CODE_MAX);

endmodule : apr_register_access
